// >>> core/sacs_clkdiv.sv
// Purpose: Converter clock enable divider.
// Assumes: DIV is two or more.
// Notes:   Produces a one-cycle enable pulse every DIV system clocks.
`timescale 1ns/1ps
module sacs_clkdiv #(
   parameter int DIV = `SACS_CONV_DIV
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Enable pulse.
   output logic      tick
);
   import sacs_pkg::*;

   // Counter and registered pulse form the whole state.
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } sacs_div_state_t;

   sacs_div_state_t s_q;  // Registered state.
   sacs_div_state_t s_d;  // Next state.

   // Count to DIV-1, then pulse once; the rate never exceeds the converter limit.
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 8'(DIV - 1)) begin
         s_d.cnt  = 8'h00;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

// >>> core/sacs_result_mem.sv
// Purpose: Per-channel result buffer with registered read data.
// Assumes: One write port and one read port, both on the system clock.
// Notes:   Contents are not cleared by reset; a slot holds until rewritten.
`timescale 1ns/1ps
module sacs_result_mem #(
   parameter int W     = `SACS_RES_W,
   parameter int DEPTH = `SACS_MEM_DEPTH
) (
   // Clock.
   input  wire logic                     clk,
   // Write port.
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [W-1:0]             wdata,
   // Read port.
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [W-1:0]             rdata
);
   import sacs_pkg::*;

   // Storage and output register together.
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0]            rdata;
   } sacs_mem_state_t;

   sacs_mem_state_t s_q;  // Registered state.
   sacs_mem_state_t s_d;  // Next state.

   // Each slot is overwritten only by its own channel's next result.
   always_comb begin
      s_d       = s_q;
      s_d.rdata = s_q.mem[raddr];
      if (we) begin
         s_d.mem[waddr] = wdata;
      end
   end

   // No reset here, so the buffer maps onto plain storage.
   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign rdata = s_q.rdata;
endmodule

// >>> core/sacs_top.sv
// Purpose: Channel sequencer and successive-approximation control with an AHB-Lite slave.
// Assumes: Comparator and sleep inputs are asynchronous; the analog core follows dac_code.
// Notes:   Reads take one wait state, writes none; responses are always OKAY.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sacs_top (
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // AHB-Lite slave.
   input  wire logic                  hsel,
   input  wire logic [7:0]            haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic      [31:0]           hrdata,
   // Analog core interface.
   input  wire logic                  comp_in,
   input  wire logic                  low_power_in,
   output logic      [3:0]            mux_sel,
   output sacs_pkg::sacs_ref_t        ref_sel,
   output logic                       sample_hold,
   output logic      [`SACS_RES_W-1:0] dac_code,
   // Interrupt.
   output logic                       irq
);
   import sacs_pkg::*;

   localparam int NSRC = `SACS_NSRC;  // Eight pins plus the temperature sensor.
   localparam int RESW = `SACS_RES_W;  // Result width.

   sacs_top_state_t s_q;               // Registered state.
   sacs_top_state_t s_d;               // Next state.
   logic            tick;              // Converter clock enable.
   logic            mem_we;            // Result buffer write strobe.
   logic [RESW-1:0] mem_rdata;         // Result buffer read data.
   logic [3:0]      mem_raddr;         // Result slot addressed by the bus.

   // Lowest enabled channel at or above a starting index; bit 4 says one was found.
   function automatic logic [4:0] sacs_pick(input logic [NSRC-1:0] msk,
                                            input logic [4:0]      from);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (msk[i] && (5'(i) >= from)) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // Converter clock enable, kept under the converter's rate ceiling.
   sacs_clkdiv #(
      .DIV   (`SACS_CONV_DIV)
   ) u_div (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (tick)
   );

   // One result slot per source.
   sacs_result_mem #(
      .W     (RESW),
      .DEPTH (`SACS_MEM_DEPTH)
   ) u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (s_q.chan),
      .wdata (s_q.dac),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   // The buffer is read in the address phase so data is ready for the wait state.
   assign mem_raddr = haddr[5:2];

   // Bus slave, register file, sequencer and interrupt logic in one next-state process.
   always_comb begin
      logic       run;        // Converter allowed to work.
      logic       accept;     // Address phase taken this cycle.
      logic [2:0] ev;         // Events raised this cycle.
      logic [2:0] clr;        // Sticky bits cleared by a status read.
      logic [4:0] pk;         // Channel pick result.
      logic       finish;     // Last conversion clock of a result.
      logic [31:0] rd;        // Read mux.
      run    = 1'b0;
      accept = 1'b0;
      ev     = 3'b000;
      clr    = 3'b000;
      pk     = 5'h00;
      finish = 1'b0;
      rd     = 32'h0000_0000;
      mem_we = 1'b0;
      s_d    = s_q;

      // Two-flop synchronisers; only the second stage is used below.
      s_d.comp_s1  = comp_in;
      s_d.comp_s2  = s_q.comp_s1;
      s_d.sleep_s1 = low_power_in;
      s_d.sleep_s2 = s_q.sleep_s1;

      // Data phase of a write: commit to the addressed register.
      if (s_q.wr_pend) begin
         s_d.wr_pend = 1'b0;
         case (s_q.addr)
            `SACS_OFF_CTRL: begin
               s_d.en         = hwdata[`SACS_CTRL_EN];
               s_d.fw_mode    = hwdata[`SACS_CTRL_FW];
               s_d.cont       = hwdata[`SACS_CTRL_CONT];
               s_d.ref_sel    = sacs_ref_t'(hwdata[`SACS_CTRL_REF +: 2]);
               s_d.fw_chan    = hwdata[`SACS_CTRL_CH +: 4];
               if (hwdata[`SACS_CTRL_START]) begin
                  s_d.start_pend = 1'b1;
               end
            end
            `SACS_OFF_CHEN: begin
               s_d.chan_en = hwdata[NSRC-1:0];
            end
            `SACS_OFF_MASK: begin
               s_d.mask = hwdata[2:0];
            end
            `SACS_OFF_LIMIT: begin
               s_d.lim_lo = hwdata[RESW-1:0];
               s_d.lim_hi = hwdata[`SACS_LIMIT_HI +: RESW];
            end
            `SACS_OFF_SMP0: begin
               // Sample times for the eight pin channels, four bits each.
               for (int i = 0; i < 8; i++) begin
                  s_d.smp_time[i] = hwdata[4*i +: 4];
               end
            end
            `SACS_OFF_SMP1: begin
               s_d.smp_time[`SACS_TEMP_CH] = hwdata[3:0];
            end
            default: begin
               // Read-only and unmapped words ignore writes.
            end
         endcase
      end

      // Wait state of a read: the buffer output is valid now, so answer.
      if (s_q.rd_pend) begin
         s_d.rd_pend = 1'b0;
         s_d.hready  = 1'b1;
         if (s_q.addr[7:6] == 2'b01) begin
            rd = {{(32 - RESW){1'b0}}, mem_rdata};
         end else begin
            case (s_q.addr)
               `SACS_OFF_CTRL: begin
                  rd[`SACS_CTRL_EN]      = s_q.en;
                  rd[`SACS_CTRL_FW]      = s_q.fw_mode;
                  rd[`SACS_CTRL_CONT]    = s_q.cont;
                  rd[`SACS_CTRL_START]   = s_q.start_pend;
                  rd[`SACS_CTRL_REF +: 2] = s_q.ref_sel;
                  rd[`SACS_CTRL_CH +: 4]  = s_q.fw_chan;
               end
               `SACS_OFF_CHEN: begin
                  rd[NSRC-1:0] = s_q.chan_en;
               end
               `SACS_OFF_STATUS: begin
                  rd[2:0]                 = s_q.sticky;
                  rd[`SACS_STAT_BUSY]     = (s_q.st != SACS_IDLE);
                  rd[`SACS_STAT_CH +: 4]  = s_q.chan;
                  clr                     = s_q.sticky;  // Read clears what it returned.
               end
               `SACS_OFF_MASK: begin
                  rd[2:0] = s_q.mask;
               end
               `SACS_OFF_LIMIT: begin
                  rd[RESW-1:0]               = s_q.lim_lo;
                  rd[`SACS_LIMIT_HI +: RESW] = s_q.lim_hi;
               end
               `SACS_OFF_SMP0: begin
                  for (int i = 0; i < 8; i++) begin
                     rd[4*i +: 4] = s_q.smp_time[i];
                  end
               end
               `SACS_OFF_SMP1: begin
                  rd[3:0] = s_q.smp_time[`SACS_TEMP_CH];
               end
               default: begin
                  rd = 32'h0000_0000;  // Unmapped words read as zero.
               end
            endcase
         end
         s_d.hrdata = rd;
      end

      // Address phase: only word transfers are taken; others complete with no effect.
      accept = hsel && hready && htrans[1] && (hsize == 3'h2);
      if (accept) begin
         s_d.addr = {haddr[7:2], 2'b00};
         if (hwrite) begin
            s_d.wr_pend = 1'b1;
         end else begin
            s_d.rd_pend = 1'b1;
            s_d.hready  = 1'b0;  // One wait state covers the buffer read latency.
         end
      end

      // The converter only works while enabled and not in a deep low-power mode.
      run = s_q.en && !s_q.sleep_s2;

      // Sequencer state machine, advanced on the converter clock enable.
      case (s_q.st)
         SACS_IDLE: begin
            s_d.sample = 1'b0;
            if (run && s_q.start_pend && tick) begin
               s_d.start_pend = 1'b0;
               if (s_q.fw_mode) begin
                  // Firmware names the channel, including the temperature sensor.
                  if (s_q.fw_chan < 4'(NSRC)) begin
                     s_d.chan    = s_q.fw_chan;
                     s_d.smp_cnt = s_q.smp_time[s_q.fw_chan];
                     s_d.sample  = 1'b1;
                     s_d.st      = SACS_SAMPLE;
                  end
               end else begin
                  // Internal scan begins at the lowest enabled channel.
                  pk = sacs_pick(s_q.chan_en, 5'h00);
                  if (pk[4]) begin
                     s_d.chan    = pk[3:0];
                     s_d.smp_cnt = s_q.smp_time[pk[3:0]];
                     s_d.sample  = 1'b1;
                     s_d.st      = SACS_SAMPLE;
                  end
               end
            end
         end
         SACS_SAMPLE: begin
            // The hold window lasts the channel's programmed count plus one clock.
            if (tick) begin
               if (s_q.smp_cnt == 4'h0) begin
                  s_d.sample  = 1'b0;
                  s_d.st      = SACS_CONVERT;
                  s_d.cnv_cnt = 5'h00;
                  s_d.bitpos  = 4'(RESW - 1);
                  s_d.dac     = {1'b1, {(RESW - 1){1'b0}}};
               end else begin
                  s_d.smp_cnt = s_q.smp_cnt - 4'h1;
               end
            end
         end
         SACS_CONVERT: begin
            if (tick) begin
               // One bit decided per converter clock for the first RESW clocks.
               if (s_q.cnv_cnt < 5'(RESW)) begin
                  if (!s_q.comp_s2) begin
                     s_d.dac[s_q.bitpos] = 1'b0;
                  end
                  if (s_q.bitpos != 4'h0) begin
                     s_d.dac[s_q.bitpos - 4'h1] = 1'b1;
                     s_d.bitpos                 = s_q.bitpos - 4'h1;
                  end
               end
               // Padding clocks bring every conversion to the full count.
               if (s_q.cnv_cnt == 5'(`SACS_CONV_CLKS - 1)) begin
                  finish = 1'b1;
               end else begin
                  s_d.cnv_cnt = s_q.cnv_cnt + 5'h01;
               end
            end
         end
         default: begin
            s_d.st = SACS_IDLE;
         end
      endcase

      // Result handling: store, check, then in a scan move straight on to the next channel; otherwise go idle.
      if (finish) begin
         mem_we            = 1'b1;
         ev[`SACS_EV_CONV] = 1'b1;
         // Checked per result, so a stray value is seen before the scan ends.
         if ((s_q.dac < s_q.lim_lo) || (s_q.dac > s_q.lim_hi)) begin
            ev[`SACS_EV_OOR] = 1'b1;
         end
         s_d.st = SACS_IDLE;
         if (!s_q.fw_mode) begin
            pk = sacs_pick(s_q.chan_en, 5'(s_q.chan) + 5'h01);
            if (!pk[4]) begin
               ev[`SACS_EV_SCAN] = 1'b1;
               if (s_q.cont) begin
                  pk = sacs_pick(s_q.chan_en, 5'h00);
               end
            end
            // Sampling of the next channel starts on the same converter clock that ends this conversion.
            if (pk[4]) begin
               s_d.chan    = pk[3:0];
               s_d.smp_cnt = s_q.smp_time[pk[3:0]];
               s_d.sample  = 1'b1;
               s_d.st      = SACS_SAMPLE;
            end
         end
      end

      // Losing the enable or entering low power abandons any conversion.
      if (!run) begin
         s_d.st     = SACS_IDLE;
         s_d.sample = 1'b0;
      end

      // Sticky events: a set in the same cycle as a read clear wins.
      s_d.sticky = (s_q.sticky & ~clr) | ev;
      s_d.irq    = |(s_d.sticky & s_q.mask);
   end

   // State register with constant reset values.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q          <= '0;
         s_q.hready   <= 1'b1;
         s_q.st       <= SACS_IDLE;
         s_q.ref_sel  <= SACS_REF_VDD;
         s_q.chan_en  <= `SACS_CHEN_RST;
         s_q.smp_time <= {NSRC{`SACS_SMP_RST}};
         s_q.lim_lo   <= `SACS_LIM_LO_RST;
         s_q.lim_hi   <= `SACS_LIM_HI_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Every output is a field of the state register.
   assign hreadyout   = s_q.hready;
   assign hresp       = s_q.hresp;
   assign hrdata      = s_q.hrdata;
   assign mux_sel     = s_q.chan;
   assign ref_sel     = s_q.ref_sel;
   assign sample_hold = s_q.sample;
   assign dac_code    = s_q.dac;
   assign irq         = s_q.irq;
endmodule

// >>> shared/sacs_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes: A 40 MHz system clock and a register bus with 32-bit aligned words.
// Notes:   Definitions only; included by the package alone; the design modules use its macros.
`ifndef SACS_CFG_SVH
`define SACS_CFG_SVH

// Clock rates and the derived converter clock divider (rounded up so the rate never exceeds).
`define SACS_SYS_HZ       40000000
`define SACS_CONV_MAX_HZ  14500000
`define SACS_CONV_DIV     ((`SACS_SYS_HZ + `SACS_CONV_MAX_HZ - 1) / `SACS_CONV_MAX_HZ)
`define SACS_CONV_CLKS    18

// Converter geometry.
`define SACS_RES_W        12
`define SACS_NSRC         9
`define SACS_TEMP_CH      8
`define SACS_MEM_DEPTH    16

// Register byte offsets.
`define SACS_OFF_CTRL     8'h00
`define SACS_OFF_CHEN     8'h04
`define SACS_OFF_STATUS   8'h08
`define SACS_OFF_MASK     8'h0C
`define SACS_OFF_LIMIT    8'h10
`define SACS_OFF_SMP0     8'h18
`define SACS_OFF_SMP1     8'h1C
`define SACS_OFF_RESULT   8'h40

// Control register fields.
`define SACS_CTRL_EN      0
`define SACS_CTRL_FW      1
`define SACS_CTRL_CONT    2
`define SACS_CTRL_START   3
`define SACS_CTRL_REF     4
`define SACS_CTRL_CH      8

// Status register fields and the limit register high field.
`define SACS_EV_CONV      0
`define SACS_EV_SCAN      1
`define SACS_EV_OOR       2
`define SACS_STAT_BUSY    8
`define SACS_STAT_CH      12
`define SACS_LIMIT_HI     16

// Reset values.
`define SACS_CHEN_RST     9'h0FF
`define SACS_SMP_RST      4'h3
`define SACS_LIM_LO_RST   12'h000
`define SACS_LIM_HI_RST   12'hFFF

`endif

// >>> shared/sacs_pkg.sv
// Purpose: Types shared by the converter sequencer modules.
// Assumes: The configuration header supplies the channel count and result width used here.
// Notes:   State structs follow the one-struct-per-module house idiom.
package sacs_pkg;
`include "sacs_cfg.svh"

   // Sequencer states.
   typedef enum logic [1:0] {
      SACS_IDLE    = 2'b00,
      SACS_SAMPLE  = 2'b01,
      SACS_CONVERT = 2'b10
   } sacs_state_t;

   // Reference selection codes driven to the analog reference mux.
   typedef enum logic [1:0] {
      SACS_REF_VDD  = 2'b00,
      SACS_REF_HALF = 2'b01,
      SACS_REF_INT  = 2'b10,
      SACS_REF_EXT  = 2'b11
   } sacs_ref_t;

   // Complete state of the top module.
   typedef struct packed {
      logic                                rd_pend;
      logic                                wr_pend;
      logic [7:0]                          addr;
      logic [31:0]                         hrdata;
      logic                                hready;
      logic                                hresp;
      logic                                en;
      logic                                fw_mode;
      logic                                cont;
      sacs_ref_t                           ref_sel;
      logic [3:0]                          fw_chan;
      logic                                start_pend;
      logic [`SACS_NSRC-1:0]               chan_en;
      logic [`SACS_NSRC-1:0][3:0]          smp_time;
      logic [`SACS_RES_W-1:0]              lim_lo;
      logic [`SACS_RES_W-1:0]              lim_hi;
      logic [2:0]                          sticky;
      logic [2:0]                          mask;
      logic                                irq;
      logic                                comp_s1;
      logic                                comp_s2;
      logic                                sleep_s1;
      logic                                sleep_s2;
      sacs_state_t                         st;
      logic [3:0]                          chan;
      logic [3:0]                          smp_cnt;
      logic [4:0]                          cnv_cnt;
      logic [3:0]                          bitpos;
      logic [`SACS_RES_W-1:0]              dac;
      logic                                sample;
   } sacs_top_state_t;

endpackage

// >>> sim/sacs_analog.sv
// Purpose: Behavioural analog core: input mux, track and hold, comparator.
// Assumes: Levels are given in LSB of the 12-bit range.
// Notes:   A half-LSB offset makes the ideal result equal the level.
`timescale 1ns/1ps
module sacs_analog (
   // Controls from the sequencer.
   input wire logic [3:0]       mux_sel,
   input wire logic             sample_hold,
   input wire logic [11:0]      dac_code,
   // Channel levels, index 8 is the temperature sensor.
   input wire logic [8:0][11:0] vin,
   // Comparator decision.
   output logic                 comp_in
);
   logic [11:0] held; // Held level; it must not follow the input during conversion.
   // Track while the window is open, hold afterwards.
   always_latch begin
      if (sample_hold) begin
         held = vin[mux_sel];
      end
   end
   // Settles at once, well inside one clock of a trial code change.
   assign comp_in = {held, 1'b1} > {dac_code, 1'b0};
endmodule

// >>> sim/sacs_chk.sv
// Purpose: Port-level checks of the converter sequencer.
// Assumes: hready is tied to hreadyout by the bench.
// Notes:   Bound to the top module from the bench file.
`timescale 1ns/1ps
module sacs_chk (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       rst_n,
   // Bus.
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic [2:0] hsize,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // Analog side and interrupt.
   input wire logic       low_power_in,
   input wire logic [3:0] mux_sel,
   input wire logic       sample_hold,
   input wire logic       irq
);
   logic [5:0] low_q; // Low cycles of sample_hold, saturating so it stays small.
   logic       take;  // A word transfer is taken at this edge.
   assign take = hsel && hready && htrans[1] && hsize == 3'h2;
   // Count idle cycles between acquisition windows.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_q <= 6'h3F;
      end else if (sample_hold) begin
         low_q <= 6'h00;
      end else if (low_q != 6'h3F) begin
         low_q <= low_q + 6'h01;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_resp_okay: assert property (!hresp) else $error("error response seen");
   a_rd_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_wr_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
   a_wait_once: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
   a_rst_quiet: assert property ($rose(rst_n) |-> hreadyout && !irq && !sample_hold)
      else $error("outputs busy after reset");
   a_chan_range: assert property (mux_sel <= 4'h8) else $error("bad channel");
   a_sleep_abort: assert property (low_power_in [*3] |=> !sample_hold)
      else $error("sampling in sleep");
   a_smp_min: assert property ($rose(sample_hold) |-> sample_hold [*3] or ##[0:2] low_power_in)
      else $error("window too short");
   a_conv_len: assert property ($rose(sample_hold) |-> low_q >= 6'h35)
      else $error("conversion too short");
   // Main scenarios.
   c_irq: cover property ($rose(irq));
   c_temp: cover property ($rose(sample_hold) && mux_sel == 4'h8);
   c_read: cover property (take && !hwrite);
endmodule

// >>> sim/sar_adc_channel_sequencer_test.sv
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: One system clock at 40 MHz.
// Notes:   Reads are checked by a monitor from a queue of notes.
`timescale 1ns/1ps
module sar_adc_channel_sequencer_test;
   import sacs_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFFFFFF; // Compare every bit.
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, comp_in, low_power_in, sample_hold, irq;
   logic [7:0]       haddr;
   logic [1:0]       htrans, rf;
   logic [2:0]       hsize;
   logic [31:0]      hwdata, hrdata, smp;
   logic [3:0]       mux_sel;
   sacs_ref_t        ref_sel;
   logic [11:0]      dac_code, lo, hcnt;
   logic [8:0][11:0] vin;      // Channel levels.
   logic [8:0]       chen;
   logic             oor, rd_dp;
   logic [63:0]      notes[$]; // Read notes: mask over value.
   logic [15:0]      seen[$];  // Windows: channel over length.
   int err_total, compares, cyc;
   sacs_top sacs_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_in(comp_in),
      .low_power_in(low_power_in), .mux_sel(mux_sel), .ref_sel(ref_sel),
      .sample_hold(sample_hold), .dac_code(dac_code), .irq(irq));
   sacs_analog sacs_analog_i (.mux_sel(mux_sel), .sample_hold(sample_hold),
      .dac_code(dac_code), .vin(vin), .comp_in(comp_in));
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Compare under a mask; unknowns never match.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      compares++;
      if (((got ^ exp) & m) !== 32'h0) begin
         err_total++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("Counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One single-word transfer; for a read, d is the expected value.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) notes.push_back({m, d});
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask
   // Bounded wait for the interrupt line.
   task automatic wait_irq;
      for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
      chk({31'h0, irq}, 32'h1, 32'h1);
   endtask
   // Monitor: read data against notes, window lengths, hang limit.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         close_out();
      end else begin
         if (rd_dp && hreadyout) begin
            rd_dp = 1'b0;
            chk(hrdata, notes[0][31:0], notes[0][63:32]);
            notes.pop_front();
         end
         if (hreadyout && htrans == 2'h2 && !hwrite) rd_dp = 1'b1;
         if (sample_hold) hcnt++;
         else if (hcnt != 12'h0) begin
            seen.push_back({mux_sel, hcnt});
            hcnt = 12'h0;
         end
      end
   end
   initial begin
      {hsel, hsize, htrans, haddr, hwrite, hwdata} = {1'b1, 3'h2, 2'h0, 8'h00, 1'b0, 32'h0};
      {rst_n, low_power_in, rd_dp, hcnt, err_total, compares, cyc} = '0;
      void'($urandom(51436));
      for (int i = 0; i < 9; i++) vin[i] = 12'($urandom);
      vin[8][11] = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and an unmapped place.
      bus(1, 8'h20, ALL, 0);
      bus(0, 8'h00, 32'h0, ALL);
      bus(0, 8'h04, 32'h0FF, ALL);
      bus(0, 8'h08, 32'h0, ALL);
      bus(0, 8'h10, 32'h0FFF0000, 32'h0FFF0FFF);
      bus(0, 8'h18, 32'h33333333, ALL);
      bus(0, 8'h20, 32'h0, ALL);
      $display("Test reset done");
      // Single automatic scan over a random channel set.
      chen = 9'($urandom) & 9'h07F | 9'h080;
      smp = $urandom;
      lo = 12'($urandom % 2048);
      rf = 2'($urandom);
      bus(1, 8'h04, 32'(chen), 0);
      bus(1, 8'h18, smp, 0);
      bus(1, 8'h10, {4'h0, lo + 12'h400, 4'h0, lo}, 0);
      bus(0, 8'h10, {4'h0, lo + 12'h400, 4'h0, lo}, ALL);
      bus(1, 8'h0C, 32'h2, 0);
      bus(1, 8'h00, {26'h0, rf, 4'h9}, 0);
      wait_irq();
      oor = 1'b0;
      for (int i = 0; i < 8; i++) if (chen[i]) oor |= vin[i] < lo || vin[i] > lo + 12'h400;
      bus(0, 8'h08, {29'h0, oor, 2'h3}, 32'h107);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0, 32'h1);
      chk({30'h0, ref_sel}, {30'h0, rf}, ALL);
      for (int i = 0; i < 8; i++) begin
         if (chen[i]) begin
            bus(0, 8'(8'h40 + 4 * i), {20'h0, vin[i]}, 32'hFFF);
            chk({16'h0, seen.pop_front()}, {16'h0, 4'(i), 12'((smp[4*i+:4] + 1) * 3)}, ALL);
         end
      end
      $display("Test scan done");
      // Firmware conversion of the temperature sensor, out of range low.
      bus(1, 8'h10, {16'h0FFF, 4'h0, vin[8] + 12'h1}, 0);
      bus(1, 8'h0C, 32'h4, 0);
      bus(1, 8'h00, 32'h0000080B, 0);
      wait_irq();
      bus(0, 8'h08, 32'h5, 32'h107);
      bus(0, 8'h60, {20'h0, vin[8]}, 32'hFFF);
      $display("Test firmware done");
      // Continuous scan restarts, then sleep stops it.
      seen.delete();
      bus(1, 8'h04, 32'h3, 0);
      bus(1, 8'h18, 32'h0, 0);
      bus(1, 8'h00, 32'hD, 0);
      for (int n = 0; n < 2000 && seen.size() < 3; n++) @(posedge clk);
      for (int i = 0; i < 3; i++) chk({28'h0, seen[i][15:12]}, 32'(i % 2), ALL);
      low_power_in <= 1'b1;
      repeat (6) @(posedge clk);
      chk({31'h0, sample_hold}, 32'h0, 32'h1);
      bus(0, 8'h08, 32'h0, 32'h100);
      bus(1, 8'h00, 32'h0, 0);
      low_power_in <= 1'b0;
      $display("Test sleep done");
      close_out();
   end
endmodule
bind sacs_top sacs_chk sacs_chk_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .low_power_in(low_power_in), .mux_sel(mux_sel), .sample_hold(sample_hold), .irq(irq));
